/* shared/ashp_defines.vh */
// Purpose: constants for the converter serial host port
// Assumes: included by bare name from src files
// Notes: definitions only
`ifndef ASHP_DEFINES_VH
`define ASHP_DEFINES_VH
`define ASHP_WORD_BITS 16
`define ASHP_CNT_W 5
`define ASHP_CNT_LAST 5'h10
`define ASHP_CMD_HI 15
`define ASHP_CMD_LO 12
`define ASHP_CFG_HI 11
`define ASHP_CMD_WRITE_CFG 4'hA
`define ASHP_CMD_READ_BUF 4'hE
`define ASHP_CMD_W_CFG 4'h7
`define ASHP_CMD_W_LAST 4'hF
`define ASHP_CFG_RESET 12'h000
`define ASHP_CFG_EXTCLK_BIT 10
`define ASHP_CFG_MODE_HI 6
`define ASHP_CFG_MODE_LO 5
`define ASHP_MODE_00 2'h0
`endif

/* src/ashp_sync.v */
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: d comes from outside the core clock domain
// Notes: stage one feeds stage two only
`timescale 1ns/100ps
module ashp_sync #(
	parameter RESET_VAL = 1'b0
) (
	// clock and control
	input wire clk,
	input wire rst_n,
	input wire ce,
	// level
	input wire d,
	output reg q
);
	reg meta_q;

	always @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			q <= RESET_VAL;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

/* src/ashp_port.v */
// Purpose: serial command and result port of a multichannel converter
// Assumes: all pins are oversampled by CORE_CLK, far faster than the serial clock
// Notes: the core feeds result words in; the port returns commands and configuration
//
// Summary of operation
// - serial clock edges shift data only while slave select is low.
// - with external conversion clock configured, serial clock is the conversion clock always.
// - top four input bits decode as one command code.
// - configuration write carries twelve data bits captured as the new configuration.
// - top input bit latched on first falling edge after frame sync rises or select falls.
// - host changes later bits on rising edge; device captures on next falling edge.
// - input ignored after sixteen edges or select rising, whichever comes first.
// - output floats while select is high, driven after select falls.
// - output word sent most significant bit first.
// - frame sync cycle: top output bit valid before first falling edge.
// - select cycle: top output bit valid before first falling edge.
// - remaining output bits change on rising edge, host samples on falling.
// - conversion cycle puts previous result in the leading output bits.
// - buffer read puts previous result in the top four output bits, oldest buffered result after them.
// - output floats at the sixteenth falling edge of a cycle.
// - output floats during conversions in modes 01, 10 and 11.
// - frame sync low at select fall: cycle starts at frame sync rise, counter cleared.
`timescale 1ns/100ps
`include "ashp_defines.vh"
module ashp_port #(
	parameter RES_BITS = 14
) (
	// clock, reset, enable
	input wire CORE_CLK,
	input wire RST_N,
	input wire CE,
	// serial pins
	input wire SCLK,
	input wire CS_N,
	input wire FRAME_SYNC,
	input wire SDI,
	output reg SDO_O,
	output wire SDO_OE,
	// converter core side
	input wire [RES_BITS-1:0] CONV_RESULT,
	input wire [RES_BITS-1:0] BUF_OLDEST,
	input wire CONV_BUSY,
	output reg [3:0] CMD_CODE,
	output reg CMD_VALID,
	output reg [11:0] CONFIG,
	output reg CONFIG_WR,
	output wire EXT_CONV_CLK_EN,
	output wire CONV_CLK_TICK
);
	localparam PAD = `ASHP_WORD_BITS - RES_BITS;
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT_FS = 2'h1;
	localparam ST_XFER = 2'h2;
	localparam ST_DONE = 2'h3;

	wire sclk_s;
	wire cs_n_s;
	wire fs_s;
	wire sdi_s;
	reg sclk_q;
	reg cs_n_q;
	reg fs_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [`ASHP_CNT_W-1:0] cnt_q;
	reg [`ASHP_WORD_BITS-1:0] in_q;
	reg [`ASHP_WORD_BITS-1:0] out_q;
	reg drive_q;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	ashp_sync #(.RESET_VAL(1'b0)) u_sclk (
		.clk(CORE_CLK), .rst_n(RST_N), .ce(CE), .d(SCLK), .q(sclk_s)
	);
	ashp_sync #(.RESET_VAL(1'b0)) u_cs (
		.clk(CORE_CLK), .rst_n(RST_N), .ce(CE), .d(~CS_N), .q(cs_n_s)
	);
	ashp_sync #(.RESET_VAL(1'b0)) u_fs (
		.clk(CORE_CLK), .rst_n(RST_N), .ce(CE), .d(~FRAME_SYNC), .q(fs_s)
	);
	ashp_sync #(.RESET_VAL(1'b0)) u_sdi (
		.clk(CORE_CLK), .rst_n(RST_N), .ce(CE), .d(SDI), .q(sdi_s)
	);

	// cs and fs are synchronised inverted so reset reads as deselected / idle-high
	wire sel = cs_n_s;
	wire fs_hi = ~fs_s;
	wire sclk_rise = sclk_s & ~sclk_q;
	wire sclk_fall = ~sclk_s & sclk_q;
	wire sel_fall = sel & cs_n_q;
	wire fs_rise = fs_hi & ~fs_q;
	wire busy_float = CONV_BUSY & (CONFIG[`ASHP_CFG_MODE_HI:`ASHP_CFG_MODE_LO] != `ASHP_MODE_00);
	wire [`ASHP_WORD_BITS-1:0] in_next = {in_q[`ASHP_WORD_BITS-2:0], sdi_s};
	// after four shifts the command nibble still sits at the low end of the shifter
	wire [3:0] cmd_next = in_next[`ASHP_CMD_HI-`ASHP_CMD_LO:0];
	wire is_read_buf = (cmd_next == `ASHP_CMD_READ_BUF);

	////////////////////////////////////////////////////////////////////////////
	// conversion clock from the serial clock, independent of select
	assign EXT_CONV_CLK_EN = CONFIG[`ASHP_CFG_EXTCLK_BIT];
	assign CONV_CLK_TICK = EXT_CONV_CLK_EN & sclk_rise;

	// output floats when deselected, after word end, or during busy conversions in modes other than 00
	assign SDO_OE = sel & drive_q & ~busy_float;

	////////////////////////////////////////////////////////////////////////////
	// cycle sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (sel_fall) begin
				if (fs_hi) begin
					state_d = ST_XFER;
				end else begin
					state_d = ST_WAIT_FS;
				end
			end
		end
		ST_WAIT_FS: begin
			if (!sel) begin
				state_d = ST_IDLE;
			end else if (fs_rise) begin
				state_d = ST_XFER;
			end
		end
		ST_XFER: begin
			if (!sel) begin
				state_d = ST_IDLE;
			end else if (sclk_fall && cnt_q == `ASHP_CNT_LAST - 5'h01) begin
				state_d = ST_DONE;
			end
		end
		ST_DONE: begin
			if (!sel) begin
				state_d = ST_IDLE;
			end else if (fs_rise) begin
				state_d = ST_XFER; // new dsp frame under a held select
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// shift, count and capture
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b0;
			fs_q <= 1'b1;
			state_q <= ST_IDLE;
			cnt_q <= {`ASHP_CNT_W{1'b0}};
			in_q <= {`ASHP_WORD_BITS{1'b0}};
			out_q <= {`ASHP_WORD_BITS{1'b0}};
			drive_q <= 1'b0;
			CMD_CODE <= 4'h0;
			CMD_VALID <= 1'b0;
			CONFIG <= `ASHP_CFG_RESET;
			CONFIG_WR <= 1'b0;
			SDO_O <= 1'b0;
		end else if (CE) begin
			sclk_q <= sclk_s;
			cs_n_q <= ~sel;
			fs_q <= fs_hi;
			state_q <= state_d;
			CMD_VALID <= 1'b0;
			CONFIG_WR <= 1'b0;
			if (state_q != ST_XFER && state_d == ST_XFER) begin
				cnt_q <= {`ASHP_CNT_W{1'b0}};
				in_q <= {`ASHP_WORD_BITS{1'b0}};
				drive_q <= 1'b1;
				// previous result staged; top bit goes out now, ahead of first fall
				out_q <= {CONV_RESULT, {PAD{1'b0}}};
				SDO_O <= CONV_RESULT[RES_BITS-1];
			end else if (state_q == ST_XFER && sel) begin
				if (sclk_fall) begin
					in_q <= in_next;
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q == 5'h03) begin
						CMD_CODE <= cmd_next;
						CMD_VALID <= 1'b1;
						if (is_read_buf) begin
							// fifo word replaces the fresh result for the remaining bits
							out_q <= {BUF_OLDEST, {PAD{1'b0}}};
						end
					end
					if (cnt_q == `ASHP_CNT_LAST - 5'h01) begin
						drive_q <= 1'b0;
						if (in_next[`ASHP_CMD_HI:`ASHP_CMD_LO] == `ASHP_CMD_WRITE_CFG) begin
							CONFIG <= in_next[`ASHP_CFG_HI:0];
							CONFIG_WR <= 1'b1;
						end
					end
				end
				if (sclk_rise && cnt_q != 5'h00 && cnt_q < `ASHP_CNT_LAST) begin
					// buffer read swaps source after bit 12; bits before that came from the result
					SDO_O <= out_q[`ASHP_WORD_BITS-1-cnt_q[3:0]];
				end
			end else if (!sel) begin
				drive_q <= 1'b0;
			end
		end
	end
endmodule

/* testbench/ashp_port_props.sv */
// Purpose: port checks for the serial host port
// Assumes: CE held high
// Notes: windows allow for the pin synchronisers
`timescale 1ns/100ps
module ashp_port_props #(
	parameter RES_BITS = 14
) (
	// clock and reset
	input wire CORE_CLK,
	input wire RST_N,
	// pins
	input wire SCLK,
	input wire CS_N,
	input wire FRAME_SYNC,
	input wire SDO_O,
	input wire SDO_OE,
	// core side
	input wire [RES_BITS-1:0] CONV_RESULT,
	input wire CONV_BUSY,
	input wire CMD_VALID,
	input wire [11:0] CONFIG,
	input wire CONFIG_WR,
	input wire EXT_CONV_CLK_EN,
	input wire CONV_CLK_TICK
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	property p_flt; CS_N [*5] |-> !SDO_OE; endproperty
	a_flt: assert property (p_flt) else $error("sdo driven");
	property p_drv; $fell(CS_N) && FRAME_SYNC && !CONV_BUSY ##1 !CS_N [*5]
		|-> SDO_OE && SDO_O == CONV_RESULT[RES_BITS-1]; endproperty
	a_drv: assert property (p_drv) else $error("top bit late");
	property p_bsy; !CS_N && CONV_BUSY && CONFIG[6:5] != 2'h0 |-> !SDO_OE; endproperty
	a_bsy: assert property (p_bsy) else $error("sdo driven busy");
	property p_ext; EXT_CONV_CLK_EN == CONFIG[10]; endproperty
	a_ext: assert property (p_ext) else $error("ext clk flag");
	property p_tck; $rose(SCLK) && EXT_CONV_CLK_EN |-> ##[2:5] CONV_CLK_TICK; endproperty
	a_tck: assert property (p_tck) else $error("no tick");
	property p_rel; $rose(CS_N) |-> ##[1:5] !SDO_OE; endproperty
	a_rel: assert property (p_rel) else $error("sdo held");
	property p_cfg; !CONFIG_WR && !$past(CONFIG_WR) |-> $stable(CONFIG); endproperty
	a_cfg: assert property (p_cfg) else $error("config moved");
	property p_cmd; CMD_VALID |=> !CMD_VALID; endproperty
	a_cmd: assert property (p_cmd) else $error("long pulse");
endmodule
////////////////////////////////
bind ashp_port ashp_port_props #(.RES_BITS(RES_BITS)) u_props (.*);

/* testbench/ashp_host_model.sv */
// Purpose: serial master beside the port
// Assumes: clk is the core clock
// Notes: sclk half period is 8 core cycles
`timescale 1ns/100ps
module ashp_host_model (
	// clock and returned data
	input wire clk,
	input wire sdo,
	// driven pins
	output logic sclk,
	output logic cs_n,
	output logic fs,
	output logic sdi
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		fs = 1'b1;
		sdi = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	// n below 16 gives a short frame cut by select
	task automatic xfer(input logic [15:0] tx, input logic use_fs, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		fs = !use_fs;
		wt(1);
		cs_n = 1'b0;
		wt(8);
		if (use_fs) begin
			fs = 1'b1;
			wt(8);
			fs = 1'b0;
		end
		for (int i = 15; i > 15 - n; i--) begin
			sdi = tx[i];
			sclk = 1'b1;
			wt(8);
			sclk = 1'b0;
			rx[i] = sdo;
			wt(8);
		end
		cs_n = 1'b1;
		fs = 1'b1;
		sdi = 1'b1;
		wt(8);
	endtask
	// free clock with select high, for the conversion clock
	task automatic spin(input int n);
		repeat (n) begin
			sclk = 1'b1;
			wt(8);
			sclk = 1'b0;
			wt(8);
		end
	endtask
endmodule

/* testbench/ashp_port_tb.sv */
// Purpose: self-checking bench for the serial host port
// Assumes: host model drives every serial input pin
// Notes: CE tied high
`timescale 1ns/100ps
module ashp_port_tb;
	logic clk, rst_n, busy;
	logic [13:0] res, bufw;
	logic [15:0] rx;
	wire sclk, cs_n, fs, sdi, sdo_o, sdo_oe, ext;
	wire [3:0] cmd;
	wire [11:0] cfg;
	int err_total, comparisons;
	// the pin floats when the port lets go
	wire sdo = sdo_oe ? sdo_o : 1'bz;
	ashp_port dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(1'b1), .SCLK(sclk), .CS_N(cs_n),
		.FRAME_SYNC(fs), .SDI(sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .CONV_RESULT(res),
		.BUF_OLDEST(bufw), .CONV_BUSY(busy), .CMD_CODE(cmd), .CMD_VALID(), .CONFIG(cfg),
		.CONFIG_WR(), .EXT_CONV_CLK_EN(ext), .CONV_CLK_TICK());
	ashp_host_model h (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .fs(fs), .sdi(sdi));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic t_conv(input logic use_fs);
		h.xfer(16'h1000, use_fs, 16, rx);
		chk(rx, {res, 2'h0});
		chk(cmd, 4'h1);
		chk(sdo_oe, 1'b0);
	endtask
	task automatic t_buf;
		h.xfer(16'hE000, 1'b0, 16, rx);
		chk(rx, {res[13:10], bufw[9:0], 2'h0});
	endtask
	task automatic t_cfg;
		h.xfer(16'hA4A5, 1'b0, 10, rx);
		chk(cfg, 16'h0000);
		h.xfer(16'hA4A5, 1'b0, 16, rx);
		chk(cfg, 16'h04A5);
		h.spin(3);
		chk(ext, 1'b1);
	endtask
	task automatic t_busy;
		busy = 1'b1;
		h.xfer(16'h1000, 1'b0, 16, rx);
		chk(rx, 16'hZZZZ);
		busy = 1'b0;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		busy = 1'b0;
		res = 14'h2D3C;
		bufw = 14'h1A5B;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk(sdo_oe, 1'b0);
		chk(cfg, 16'h0000);
		t_conv(1'b0);
		t_conv(1'b1);
		t_buf();
		t_cfg();
		t_busy();
		report_and_stop();
	end
endmodule
